// file: src/iif_pkg.sv
package iif_pkg;

  // handshake data settle time before the data valid strobe
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned SETTLE_NS = 2000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETTLE_W = $clog2(SETTLE_CYC + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LD = SETTLE_W'(SETTLE_CYC - 1);

  // register byte offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_COND = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_RXD = 8'h14;
  localparam logic [7:0] OFS_TXD = 8'h18;
  localparam logic [7:0] OFS_EVT = 8'h1c;

  // bus address limits, 31 means listen only
  localparam logic [7:0] ADDR_LIM = 8'h1f;
  localparam logic [4:0] ADDR_LON = 5'h1f;

  // control and event bit positions
  localparam int CTL_SVC = 0;
  localparam int CTL_CAP = 1;
  localparam int EVT_CLR = 0;
  localparam int EVT_LOST = 1;
  localparam int TXD_EOI = 8;

  // status byte layout
  localparam int STB_RQS = 6;
  localparam int COND_LRC = 3;
  localparam logic [7:0] COND_USE = 8'hbf;

  // command bytes, parity bit dropped
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;

  typedef struct packed {
    logic atn;
    logic eoi;
    logic [7:0] data;
  } iif_byte_t;

  typedef struct packed {
    logic remote;
    logic lockout;
    logic listen;
    logic talk;
    logic spe;
    logic lon;
    logic rqs;
    logic tx_busy;
  } iif_stat_t;

endpackage : iif_pkg

// file: src/iif_hs.sv
`timescale 1ns/1ns
`default_nettype none
module iif_hs (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // user side
  input wire logic acc_en_i,
  input wire logic acc_rdy_i,
  input wire logic src_en_i,
  input wire logic tx_v_i,
  input wire iif_pkg::iif_byte_t tx_i,
  output logic tx_done_o,
  output logic rx_stb_o,
  output iif_pkg::iif_byte_t rx_o,
  // bus lines, low is true
  input wire logic [7:0] dio_n_i,
  input wire logic atn_n_i,
  input wire logic eoi_n_i,
  input wire logic dav_n_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  output logic [7:0] dio_n_o,
  output logic dio_oe_o,
  output logic eoi_n_o,
  output logic eoi_oe_o,
  output logic dav_oe_o,
  output logic nrfd_oe_o,
  output logic ndac_oe_o
);
  import iif_pkg::*;

  typedef enum logic [1:0] {A_OFF, A_WAIT, A_RDY, A_HOLD} iif_acc_t;
  typedef enum logic [1:0] {S_IDLE, S_SETL, S_DAV} iif_src_t;

  iif_acc_t a_q;
  iif_src_t s_q;
  logic [SETTLE_W-1:0] cnt_q;

  // acceptor: not-ready until the user can take a byte
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_q <= A_OFF;
      nrfd_oe_o <= 1'b0;
      ndac_oe_o <= 1'b0;
      rx_stb_o <= 1'b0;
      rx_o <= '0;
    end else begin
      rx_stb_o <= 1'b0;
      if (!acc_en_i) begin
        a_q <= A_OFF;
        nrfd_oe_o <= 1'b0;
        ndac_oe_o <= 1'b0;
      end else begin
        case (a_q)
          A_OFF: begin
            a_q <= A_WAIT;
            nrfd_oe_o <= 1'b1;
            ndac_oe_o <= 1'b1;
          end
          A_WAIT: begin
            if (acc_rdy_i) begin
              a_q <= A_RDY;
              nrfd_oe_o <= 1'b0;
            end
          end
          A_RDY: begin
            if (!dav_n_i) begin
              rx_o <= '{atn: ~atn_n_i, eoi: ~eoi_n_i, data: ~dio_n_i};
              rx_stb_o <= 1'b1;
              nrfd_oe_o <= 1'b1;
              ndac_oe_o <= 1'b0;
              a_q <= A_HOLD;
            end
          end
          A_HOLD: begin
            if (dav_n_i) begin
              ndac_oe_o <= 1'b1;
              a_q <= A_WAIT;
            end
          end
          default: a_q <= A_OFF;
        endcase
      end
    end
  end

  // source: settle, wait all ready, strobe, wait all accepted
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= S_IDLE;
      cnt_q <= '0;
      dio_n_o <= 8'hff;
      dio_oe_o <= 1'b0;
      eoi_n_o <= 1'b1;
      eoi_oe_o <= 1'b0;
      dav_oe_o <= 1'b0;
      tx_done_o <= 1'b0;
    end else begin
      tx_done_o <= 1'b0;
      if (!src_en_i) begin
        s_q <= S_IDLE;
        dio_oe_o <= 1'b0;
        eoi_oe_o <= 1'b0;
        dav_oe_o <= 1'b0;
      end else begin
        case (s_q)
          S_IDLE: begin
            // tx_done gap stops a resend before the user drops valid
            if (tx_v_i && !tx_done_o) begin
              dio_n_o <= ~tx_i.data;
              eoi_n_o <= ~tx_i.eoi;
              dio_oe_o <= 1'b1;
              eoi_oe_o <= 1'b1;
              cnt_q <= SETTLE_LD;
              s_q <= S_SETL;
            end
          end
          S_SETL: begin
            if (cnt_q != '0) begin
              cnt_q <= cnt_q - 1'b1;
            end else if (nrfd_n_i) begin
              dav_oe_o <= 1'b1;
              s_q <= S_DAV;
            end
          end
          S_DAV: begin
            if (ndac_n_i) begin
              dav_oe_o <= 1'b0;
              dio_oe_o <= 1'b0;
              eoi_oe_o <= 1'b0;
              tx_done_o <= 1'b1;
              s_q <= S_IDLE;
            end
          end
          default: s_q <= S_IDLE;
        endcase
      end
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_take;
    acc_en_i && a_q == A_RDY && !dav_n_i;
  endsequence
  property p_take;
    s_take |=> rx_stb_o && nrfd_oe_o && !ndac_oe_o;
  endproperty
  a_take: assert property (p_take) else $error("offered byte not taken");

  property p_dav_rdy;
    $rose(dav_oe_o) |-> $past(nrfd_n_i) && $past(s_q) == S_SETL && dio_oe_o;
  endproperty
  a_dav_rdy: assert property (p_dav_rdy) else $error("strobe before ready");

endmodule : iif_hs
`default_nettype wire

// file: src/iif_top.sv
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - accept bus address 00 to 31 and keep it in backed-up memory
// - at power-up use switch address only when stored address is lost
// - address change in service mode turns off active controller ability
// - in remote ignore panel inputs except power and unlocked local key
// - listen addressed with remote enable: stop talking, accept data bytes
// - talk addressed: stop listening, may send output bytes
// - device clear stops talking, drops pending entries, keeps settings
// - go-to-local while listening with remote enable: stop talking, go local
// - local lockout command disables the local key, addressed or not
// - remote enable false: go local and clear lockout
// - with remote enable, go remote at every own listen address
// - raise service request when a masked-in condition occurs
// - serial poll sends one status byte, bit 6 marks request
// - interface clear drops talker and listener at once
// - group execute trigger is ignored
// - never drive data lines for a parallel poll
// - never take or pass control; controller only in service mode
// - in local still request service, answer polls, send data
// - listening and talking indicators follow addressed state
// - local key goes local unless lockout is set
// - full handshakes, basic talker and listener, no parallel poll, no trigger
// - address 31 listens to all data without addressing, stays local
// - data bytes taken only remote, listen addressed, remote enabled, or at address 31
module iif_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // bus data and handshake, low is true
  input wire logic [7:0] dio_n_i,
  output logic [7:0] dio_n_o,
  output logic dio_oe_o,
  input wire logic eoi_n_i,
  output logic eoi_n_o,
  output logic eoi_oe_o,
  input wire logic dav_n_i,
  output logic dav_n_o,
  output logic dav_oe_o,
  input wire logic nrfd_n_i,
  output logic nrfd_n_o,
  output logic nrfd_oe_o,
  input wire logic ndac_n_i,
  output logic ndac_n_o,
  output logic ndac_oe_o,
  // bus management, low is true
  input wire logic atn_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  output logic srq_n_o,
  output logic srq_oe_o,
  // backed-up address store and switch
  input wire logic nv_lost_i,
  input wire logic [4:0] nv_addr_i,
  input wire logic [4:0] switch_addr_i,
  output logic nv_we_o,
  output logic [4:0] nv_addr_o,
  // instrument side
  input wire logic [7:0] cond_evt_i,
  input wire logic local_key_i,
  output logic panel_enable_o,
  output logic ctrl_cap_o,
  output logic listening_indicator_o,
  output logic talking_indicator_o,
  output logic remote_indicator_o
);
  import iif_pkg::*;

  logic atn;
  logic ifc;
  logic ren;
  iif_byte_t rx_b;
  iif_byte_t tx_b;
  iif_byte_t rx_q;
  iif_byte_t tx_q;
  iif_stat_t st;
  logic rx_stb;
  logic tx_done;
  logic acc_en;
  logic acc_rdy;
  logic src_en;
  logic tx_req;
  logic [4:0] addr_q;
  logic boot_q;
  logic listen_q;
  logic talk_q;
  logic remote_q;
  logic lockout_q;
  logic spe_q;
  logic stb_sent_q;
  logic svc_q;
  logic ctl_q;
  logic nv_we_q;
  logic rqs_q;
  logic rsv_q;
  logic panel_q;
  logic rx_v_q;
  logic tx_v_q;
  logic [7:0] cond_q;
  logic [7:0] mask_q;
  logic [7:0] stb;
  logic [7:0] cond_set;
  logic [1:0] evt_q;
  logic [6:0] cmd;
  logic is_cmd;
  logic is_dat;
  logic lon;
  logic my_la;
  logic unl;
  logic my_ta;
  logic ot_ta;
  logic unt;
  logic llo;
  logic dev_clr;
  logic gtl;
  logic rsv;
  logic lrc;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic hit;
  logic wr;
  logic rd;

  // bus lines are low-true on the wire
  assign atn = ~atn_n_i;
  assign ifc = ~ifc_n_i;
  assign ren = ~ren_n_i;
  assign lon = (addr_q == ADDR_LON);

  // command decode; trigger, poll config and take control fall through
  assign cmd = rx_b.data[6:0];
  assign is_cmd = rx_stb & rx_b.atn;
  assign is_dat = rx_stb & ~rx_b.atn;
  assign my_la = is_cmd & ~lon & (cmd[6:5] == GRP_LISTEN) & (cmd[4:0] == addr_q);
  assign my_ta = is_cmd & ~lon & (cmd[6:5] == GRP_TALK) & (cmd[4:0] == addr_q);
  assign ot_ta = is_cmd & (cmd[6:5] == GRP_TALK) & (cmd[4:0] != addr_q);
  assign unl = is_cmd & (cmd == CMD_UNL);
  assign unt = is_cmd & (cmd == CMD_UNT);
  assign llo = is_cmd & (cmd == CMD_LLO);
  assign gtl = is_cmd & (cmd == CMD_GTL) & listen_q & ren;
  assign dev_clr = is_cmd & ((cmd == CMD_DCL) | ((cmd == CMD_SDC) & listen_q & ren));

  // acceptor joins every command; data only when allowed
  assign acc_en = atn | (listen_q & (lon | (ren & remote_q)));
  assign acc_rdy = atn | ~rx_v_q;
  // talker never drives under attention, so no parallel poll reply either
  assign src_en = talk_q & ~atn;
  assign stb = {cond_q[7], rqs_q, cond_q[5:0]};
  assign tx_b = spe_q ? '{atn: 1'b0, eoi: 1'b0, data: stb} : tx_q;
  assign tx_req = spe_q ? ~stb_sent_q : tx_v_q;

  // handshake engines, full source and acceptor
  iif_hs u_hs (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .acc_en_i(acc_en),
    .acc_rdy_i(acc_rdy),
    .src_en_i(src_en),
    .tx_v_i(tx_req),
    .tx_i(tx_b),
    .tx_done_o(tx_done),
    .rx_stb_o(rx_stb),
    .rx_o(rx_b),
    .dio_n_i(dio_n_i),
    .atn_n_i(atn_n_i),
    .eoi_n_i(eoi_n_i),
    .dav_n_i(dav_n_i),
    .nrfd_n_i(nrfd_n_i),
    .ndac_n_i(ndac_n_i),
    .dio_n_o(dio_n_o),
    .dio_oe_o(dio_oe_o),
    .eoi_n_o(eoi_n_o),
    .eoi_oe_o(eoi_oe_o),
    .dav_oe_o(dav_oe_o),
    .nrfd_oe_o(nrfd_oe_o),
    .ndac_oe_o(ndac_oe_o)
  );

  // open-drain lines only ever pull low
  assign dav_n_o = 1'b0;
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;
  assign srq_n_o = 1'b0;

  // apb: one wait state, answer registered
  assign wr = psel_i & penable_i & pready_q & pwrite_i;
  assign rd = psel_i & penable_i & pready_q & ~pwrite_i;
  assign st = '{remote: remote_q, lockout: lockout_q, listen: listen_q, talk: talk_q,
                spe: spe_q, lon: lon, rqs: rqs_q, tx_busy: tx_v_q};

  always_comb begin
    hit = 1'b1;
    case (paddr_i)
      OFS_ADDR: rd_d = {27'h0, addr_q};
      OFS_CTRL: rd_d = {30'h0, ctl_q, svc_q};
      OFS_STAT: rd_d = {24'h0, st};
      OFS_COND: rd_d = {24'h0, cond_q};
      OFS_MASK: rd_d = {24'h0, mask_q};
      OFS_RXD: rd_d = {22'h0, rx_v_q, rx_q.eoi, rx_q.data};
      OFS_TXD: rd_d = {23'h0, tx_v_q, tx_q.data};
      OFS_EVT: rd_d = {30'h0, evt_q};
      default: begin
        rd_d = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & ~hit;
      prdata_q <= (psel_i & penable_i & ~pready_q & ~pwrite_i) ? rd_d : 32'h0;
    end
  end

  // address: stored copy unless lost at power-up, then switch
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_q <= 1'b1;
      addr_q <= 5'h0;
      nv_we_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      nv_we_q <= 1'b0;
      if (boot_q) begin
        addr_q <= nv_lost_i ? switch_addr_i : nv_addr_i;
        nv_we_q <= nv_lost_i;
      end else if (wr && paddr_i == OFS_ADDR && pwdata_i[7:0] <= ADDR_LIM) begin
        addr_q <= pwdata_i[4:0];
        nv_we_q <= 1'b1;
      end
    end
  end

  // service mode and the limited controller ability
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      svc_q <= 1'b0;
      ctl_q <= 1'b0;
    end else if (wr && paddr_i == OFS_CTRL) begin
      svc_q <= pwdata_i[CTL_SVC];
      ctl_q <= pwdata_i[CTL_CAP] & pwdata_i[CTL_SVC];
    end else if (wr && paddr_i == OFS_ADDR && svc_q) begin
      ctl_q <= 1'b0;
    end
  end

  // addressed state; interface clear beats everything
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
    end else if (ifc) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
    end else if (lon) begin
      listen_q <= 1'b1;
      talk_q <= 1'b0;
    end else begin
      if (my_la) begin
        listen_q <= 1'b1;
        talk_q <= 1'b0;
      end else if (my_ta) begin
        talk_q <= 1'b1;
        listen_q <= 1'b0;
      end else begin
        if (unl) listen_q <= 1'b0;
        if (ot_ta | unt | dev_clr | gtl) talk_q <= 1'b0;
      end
    end
  end

  // remote and lockout; a locked key changes nothing
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
    end else if (!ren) begin
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
    end else begin
      if (my_la) remote_q <= 1'b1;
      else if (gtl | (local_key_i & ~lockout_q)) remote_q <= 1'b0;
      if (llo) lockout_q <= 1'b1;
    end
  end

  // serial poll mode and one status byte per poll
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      spe_q <= 1'b0;
      stb_sent_q <= 1'b0;
    end else begin
      if (ifc || (is_cmd && cmd == CMD_SPD)) spe_q <= 1'b0;
      else if (is_cmd && cmd == CMD_SPE) spe_q <= 1'b1;
      if (is_cmd && cmd == CMD_SPE) stb_sent_q <= 1'b0;
      else if (tx_done && spe_q) stb_sent_q <= 1'b1;
    end
  end

  // conditions, sticky; hardware set wins over software clear
  assign lrc = (remote_q == panel_q);
  assign cond_set = (cond_evt_i | ({7'h0, lrc} << COND_LRC)) & COND_USE;
  assign rsv = |(cond_q & mask_q);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cond_q <= 8'h0;
      mask_q <= 8'h0;
    end else begin
      if (wr && paddr_i == OFS_COND) cond_q <= (cond_q & ~pwdata_i[7:0]) | cond_set;
      else cond_q <= cond_q | cond_set;
      if (wr && paddr_i == OFS_MASK) mask_q <= pwdata_i[7:0] & COND_USE;
    end
  end

  // request stays until a poll has carried it out; works in local too
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsv_q <= 1'b0;
      rqs_q <= 1'b0;
    end else begin
      rsv_q <= rsv;
      if (rsv && !rsv_q) rqs_q <= 1'b1;
      else if (tx_done && spe_q) rqs_q <= 1'b0;
    end
  end

  // received data byte, held until software reads it
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_q <= '0;
      rx_v_q <= 1'b0;
    end else if (dev_clr) begin
      rx_v_q <= 1'b0;
    end else if (is_dat) begin
      rx_q <= rx_b;
      rx_v_q <= 1'b1;
    end else if (rd && paddr_i == OFS_RXD) begin
      rx_v_q <= 1'b0;
    end
  end

  // output byte; a write while busy is dropped
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_q <= '0;
      tx_v_q <= 1'b0;
    end else if (dev_clr) begin
      tx_v_q <= 1'b0;
    end else if (wr && paddr_i == OFS_TXD && !tx_v_q) begin
      tx_q <= '{atn: 1'b0, eoi: pwdata_i[TXD_EOI], data: pwdata_i[7:0]};
      tx_v_q <= 1'b1;
    end else if (tx_done && !spe_q) begin
      tx_v_q <= 1'b0;
    end
  end

  // events for firmware: clear seen, address lost
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_q <= 2'h0;
    end else begin
      if (dev_clr) evt_q[EVT_CLR] <= 1'b1;
      else if (wr && paddr_i == OFS_EVT && pwdata_i[EVT_CLR]) evt_q[EVT_CLR] <= 1'b0;
      if (boot_q && nv_lost_i) evt_q[EVT_LOST] <= 1'b1;
      else if (wr && paddr_i == OFS_EVT && pwdata_i[EVT_LOST]) evt_q[EVT_LOST] <= 1'b0;
    end
  end

  // panel lockout lags remote by one cycle, also gives the change edge
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) panel_q <= 1'b1;
    else panel_q <= ~remote_q;
  end

  // outputs
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign srq_oe_o = rqs_q;
  assign nv_we_o = nv_we_q;
  assign nv_addr_o = addr_q;
  assign panel_enable_o = panel_q;
  assign ctrl_cap_o = ctl_q;
  assign listening_indicator_o = listen_q;
  assign talking_indicator_o = talk_q;
  assign remote_indicator_o = remote_q;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_ren_off;
    !ren |=> !remote_q && !lockout_q;
  endproperty
  a_ren_off: assert property (p_ren_off) else $error("local not forced");

  property p_ifc;
    ifc |=> !listen_q && !talk_q && !talking_indicator_o;
  endproperty
  a_ifc: assert property (p_ifc) else $error("still addressed after clear");

  property p_mla;
    my_la && ren && !ifc |=> remote_q && listen_q && !talk_q ##1 remote_indicator_o;
  endproperty
  a_mla: assert property (p_mla) else $error("listen address mishandled");

  property p_mta;
    my_ta && !ifc |=> talk_q && !listen_q;
  endproperty
  a_mta: assert property (p_mta) else $error("talk address mishandled");

  property p_llo;
    llo && ren |=> lockout_q;
  endproperty
  a_llo: assert property (p_llo) else $error("lockout not set");

  property p_key_locked;
    lockout_q && ren && local_key_i && !gtl && !my_la |=> remote_q == $past(remote_q);
  endproperty
  a_key_locked: assert property (p_key_locked) else $error("locked key acted");

  property p_srq;
    rsv && !rsv_q |=> srq_oe_o ##1 srq_oe_o || $past(tx_done);
  endproperty
  a_srq: assert property (p_srq) else $error("service request missing");

  property p_no_poll_drive;
    atn |=> !dio_oe_o;
  endproperty
  a_no_poll_drive: assert property (p_no_poll_drive) else $error("data driven");

  property p_dcl;
    dev_clr && !ifc |=> !talk_q && !rx_v_q && !tx_v_q && evt_q[EVT_CLR];
  endproperty
  a_dcl: assert property (p_dcl) else $error("clear not applied");

  property p_gtl;
    gtl |=> !remote_q && !talk_q;
  endproperty
  a_gtl: assert property (p_gtl) else $error("go to local ignored");

endmodule : iif_top
`default_nettype wire

// file: test/iif_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
// bus controller model; released lines read high through the pull-ups
module iif_ctl_model (
  // wire levels
  input wire logic ref_clk_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  input wire logic dav_n_i,
  input wire logic [7:0] dio_n_i,
  // open-drain drives, high when released
  output logic atn_n_o,
  output logic dav_n_o,
  output logic nrfd_n_o,
  output logic ndac_n_o,
  output logic [7:0] dio_n_o
);
  logic hung = 1'b0;
  int slow = 0;
  // everything released at start
  initial begin
    {atn_n_o, dav_n_o, nrfd_n_o, ndac_n_o, dio_n_o} = '1;
  end
  // source one byte; an absent acceptor lets it pass at once
  task automatic put(input logic atn, input logic [7:0] d);
    int n;
    @(posedge ref_clk_i);
    atn_n_o <= ~atn;
    dio_n_o <= ~d;
    repeat (20) @(posedge ref_clk_i);
    for (n = 0; n < 900 && !nrfd_n_i; n++) @(posedge ref_clk_i);
    dav_n_o <= 1'b0;
    for (; n < 900 && !ndac_n_i; n++) @(posedge ref_clk_i);
    hung |= (n == 900);
    dav_n_o <= 1'b1;
    dio_n_o <= 8'hff;
    repeat (3) @(posedge ref_clk_i);
  endtask : put
  // accept one byte, slow to release not-accepted if asked
  task automatic get(output logic [7:0] d);
    int n;
    @(posedge ref_clk_i);
    atn_n_o <= 1'b1;
    ndac_n_o <= 1'b0;
    for (n = 0; n < 900 && dav_n_i; n++) @(posedge ref_clk_i);
    d = ~dio_n_i;
    nrfd_n_o <= 1'b0;
    repeat (slow) @(posedge ref_clk_i);
    ndac_n_o <= 1'b1;
    for (; n < 900 && !dav_n_i; n++) @(posedge ref_clk_i);
    hung |= (n == 900);
    nrfd_n_o <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask : get
endmodule : iif_ctl_model
`default_nettype wire

// file: test/tb_ieee488_instrument_interface.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ieee488_instrument_interface;
  import iif_pkg::*;
  logic ref_clk_i, rstn_i, psel_i, penable_i, pwrite_i, ifc_n_i, ren_n_i, nv_lost_i;
  logic local_key_i, pready_o, pslverr_o, dio_oe_o, eoi_n_o, eoi_oe_o, dav_oe_o;
  logic nrfd_oe_o, ndac_oe_o, srq_oe_o, nv_we_o, panel_enable_o, listening_indicator_o;
  logic talking_indicator_o, remote_indicator_o, c_atn, c_dav, c_nrfd, c_ndac, rerr, ctrl_cap_o;
  logic [7:0] paddr_i, cond_evt_i, dio_n_o, c_dio, b;
  logic [4:0] nv_addr_i, switch_addr_i, nv_addr_o, a;
  logic [31:0] pwdata_i, prdata_o, r;
  int err_total, checks, seed;
  // wired-and bus lines
  wire [7:0] dio_w = (dio_oe_o ? dio_n_o : 8'hff) & c_dio;
  wire eoi_w = eoi_oe_o ? eoi_n_o : 1'b1;
  wire dav_w = ~dav_oe_o & c_dav;
  wire nrfd_w = ~nrfd_oe_o & c_nrfd;
  wire ndac_w = ~ndac_oe_o & c_ndac;
  iif_top i_dut (
    .ref_clk_i, .rstn_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .dio_n_i(dio_w), .dio_n_o, .dio_oe_o,
    .eoi_n_i(eoi_w), .eoi_n_o, .eoi_oe_o, .dav_n_i(dav_w), .dav_n_o(), .dav_oe_o,
    .nrfd_n_i(nrfd_w), .nrfd_n_o(), .nrfd_oe_o, .ndac_n_i(ndac_w), .ndac_n_o(),
    .ndac_oe_o, .atn_n_i(c_atn), .ifc_n_i, .ren_n_i, .srq_n_o(), .srq_oe_o,
    .nv_lost_i, .nv_addr_i, .switch_addr_i, .nv_we_o, .nv_addr_o, .cond_evt_i,
    .local_key_i, .panel_enable_o, .ctrl_cap_o, .listening_indicator_o,
    .talking_indicator_o, .remote_indicator_o
  );
  iif_ctl_model i_ctl (
    .ref_clk_i, .nrfd_n_i(nrfd_w), .ndac_n_i(ndac_w), .dav_n_i(dav_w), .dio_n_i(dio_w),
    .atn_n_o(c_atn), .dav_n_o(c_dav), .nrfd_n_o(c_nrfd), .ndac_n_o(c_ndac), .dio_n_o(c_dio)
  );
  // expected poll byte and receive word
  function automatic logic [7:0] sbyte(input logic [7:0] c);
    return (c & COND_USE) | (8'h01 << STB_RQS);
  endfunction : sbyte
  function automatic logic [31:0] rxw(input logic [7:0] d);
    return {22'h0, 2'h2, d};
  endfunction : rxw
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1 && ++n < 9);
    r = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n == 9) begin
      err_total++;
      end_sim();
    end
  endtask : apb
  task automatic key;
    @(posedge ref_clk_i);
    local_key_i <= 1'b1;
    @(posedge ref_clk_i);
    local_key_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask : key
  // clock and watchdog
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    err_total++;
    end_sim();
  end
  // main sequence
  initial begin
    seed = 6629;
    a = 5'($unsigned($random(seed)) % 31);
    {rstn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, cond_evt_i} = '0;
    {ifc_n_i, ren_n_i, nv_lost_i, local_key_i} = 4'he;
    switch_addr_i = 5'($random(seed));
    nv_addr_i = 5'($random(seed));
    b = 8'($random(seed));
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk(nv_we_o, 1);
    chk(nv_addr_o, switch_addr_i);
    apb(0, OFS_EVT, 0);
    chk(r[EVT_LOST], 1);
    apb(1, OFS_ADDR, 32'(a));
    apb(1, OFS_ADDR, 32'h20);
    apb(0, OFS_ADDR, 0);
    chk(r, 32'(a));
    apb(1, OFS_CTRL, 32'h3);
    apb(0, OFS_CTRL, 0);
    chk({ctrl_cap_o, r[1:0]}, 7);
    apb(1, OFS_ADDR, 32'(a));
    apb(0, OFS_CTRL, 0);
    chk({ctrl_cap_o, r[1:0]}, 1);
    apb(0, 8'h40, 0);
    chk(r, 0);
    chk(rerr, 1);
    ren_n_i <= 1'b0;
    i_ctl.put(1, CMD_UNL);
    chk(remote_indicator_o, 0);
    i_ctl.put(1, {1'b0, GRP_LISTEN, a});
    chk({remote_indicator_o, listening_indicator_o}, 3);
    i_ctl.put(0, b);
    apb(0, OFS_RXD, 0);
    chk(r, rxw(b));
    key();
    chk(remote_indicator_o, 0);
    i_ctl.put(0, ~b);
    apb(0, OFS_RXD, 0);
    chk(r[9], 0);
    i_ctl.put(1, {1'b0, GRP_LISTEN, a});
    chk(panel_enable_o, 0);
    i_ctl.put(1, CMD_LLO);
    key();
    apb(0, OFS_STAT, 0);
    chk(r[7:6], 3);
    i_ctl.put(1, CMD_GTL);
    chk(remote_indicator_o, 0);
    i_ctl.put(1, {1'b0, GRP_LISTEN, a});
    ren_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    apb(0, OFS_STAT, 0);
    chk(r[7:6], 0);
    ren_n_i <= 1'b0;
    apb(1, OFS_COND, 32'hff);
    apb(1, OFS_MASK, 32'h1);
    cond_evt_i <= 8'h01;
    @(posedge ref_clk_i);
    cond_evt_i <= 8'h00;
    repeat (3) @(posedge ref_clk_i);
    chk(srq_oe_o, 1);
    i_ctl.put(1, {1'b0, GRP_TALK, a});
    chk({talking_indicator_o, listening_indicator_o}, 2);
    i_ctl.put(1, CMD_SPE);
    i_ctl.slow = 3;
    i_ctl.get(b);
    chk(b, sbyte(8'h01));
    chk(srq_oe_o, 0);
    i_ctl.put(1, CMD_SPD);
    apb(1, OFS_TXD, 32'(a));
    i_ctl.get(b);
    chk(b, 8'(a));
    i_ctl.put(1, CMD_DCL);
    apb(0, OFS_EVT, 0);
    chk(r[EVT_CLR], 1);
    i_ctl.put(1, {1'b0, GRP_LISTEN, a});
    ifc_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    ifc_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk({talking_indicator_o, listening_indicator_o}, 0);
    nv_lost_i <= 1'b0;
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk({nv_we_o, nv_addr_o}, {1'b0, nv_addr_i});
    chk(i_ctl.hung, 0);
    end_sim();
  end
endmodule : tb_ieee488_instrument_interface
`default_nettype wire
